// ==== src/mcsc_pkg.sv ====
// package for the main clock source control block
// assumes one 50 MHz core clock; slow clock and dividers are enable pulses
package mcsc_pkg;
  // clock rates and times
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int SLOW_DIV = CLK_HZ / SLOW_CLK_HZ;
  localparam int SLOW_DIV_W = 11;
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_LAST = SLOW_DIV_W'(SLOW_DIV - 1);
  localparam int XT_PRESCALE = 8;
  localparam logic [2:0] XT_PRESCALE_LAST = 3'(XT_PRESCALE - 1);
  localparam int RC_SETTLE_NS = 10_000;
  localparam int RC_SETTLE_CYC = (RC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_SETTLE_W = 10;
  localparam logic [RC_SETTLE_W-1:0] RC_SETTLE_LOAD = RC_SETTLE_W'(RC_SETTLE_CYC);
  localparam int MEAS_W = 16;
  localparam int MEAS_WIN_W = 4;
  localparam logic [MEAS_WIN_W-1:0] MEAS_WIN_LAST = 4'hf;
  localparam logic [MEAS_W-1:0] MEAS_MAX = 16'hffff;

  // register byte addresses
  localparam logic [31:0] ADDR_OSC_CTRL = 32'h400e0420;
  localparam logic [31:0] ADDR_FREQ_METER = 32'h400e0424;
  localparam logic [31:0] ADDR_USB_CFG = 32'h400e0438;
  localparam logic [31:0] ADDR_STATUS = 32'h400e0468;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h400e046c;
  localparam logic [31:0] ADDR_WPROT = 32'h400e04e4;

  // main_osc_ctrl_reg fields
  localparam int B_XT_EN = 0;
  localparam int B_XT_BYPASS = 1;
  localparam int B_RC_EN = 3;
  localparam int RC_FREQ_LSB = 4;
  localparam int RC_FREQ_W = 3;
  localparam int XT_COUNT_LSB = 8;
  localparam int XT_COUNT_W = 8;
  localparam int B_SRC_SEL = 24;
  localparam logic [RC_FREQ_W-1:0] RC_FREQ_4MHZ = 3'h0;
  localparam logic [RC_FREQ_W-1:0] RC_FREQ_8MHZ = 3'h1;
  localparam logic [RC_FREQ_W-1:0] RC_FREQ_12MHZ = 3'h2;

  // status and mask bits
  localparam int B_XT_READY = 0;
  localparam int B_SW_DONE = 16;
  localparam int B_RC_READY = 17;
  localparam int B_MEAS_READY = 16;
  localparam int B_WRITE_PROTECT_ENABLE = 0;
  localparam int USB_DIV_LSB = 8;
  localparam int USB_DIV_W = 4;

  typedef enum logic [1:0] {
    MCSC_XT_OFF,
    MCSC_XT_START,
    MCSC_XT_READY
  } mcsc_xt_state_t;
endpackage : mcsc_pkg

// ==== src/mcsc_tmr_if.sv ====
// carrier between the control core and the crystal start-up timer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface mcsc_tmr_if;
  logic slow_tick;
  logic start;
  logic stop;
  logic [7:0] load;
  logic done;
  modport ctrl (output slow_tick, output start, output stop, output load, input done);
  modport timer (input slow_tick, input start, input stop, input load, output done);
endinterface : mcsc_tmr_if
`default_nettype wire

// ==== src/mcsc_xt_timer.sv ====
// crystal start-up countdown on the slow clock divided by eight
// assumes slow_tick is a one-cycle enable from the core divider
`timescale 1ns/1ps
`default_nettype none
module mcsc_xt_timer
  import mcsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control side
  mcsc_tmr_if.timer tb
);
  typedef struct packed {
    logic [2:0] prescale;
    logic [XT_COUNT_W-1:0] cnt;
    logic busy;
    logic done;
  } mcsc_tmr_state_t;

  mcsc_tmr_state_t s;
  mcsc_tmr_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (tb.stop) begin
      next_s.busy = 1'b0;
    end else if (tb.start) begin
      next_s.cnt = tb.load;
      next_s.prescale = 3'h0;
      next_s.busy = (tb.load != '0);
      next_s.done = (tb.load == '0);
    end else if (s.busy && tb.slow_tick) begin
      if (s.prescale == XT_PRESCALE_LAST) begin
        next_s.prescale = 3'h0;
        next_s.cnt = s.cnt - 8'h01;
        if (s.cnt == 8'h01) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
      end else begin
        next_s.prescale = s.prescale + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tb.done = s.done;
endmodule : mcsc_xt_timer
`default_nettype wire

// ==== src/mcsc_usb_div.sv ====
// usb clock enable: one pulse every divider plus one input cycles
// assumes the core clock stands in for the divider's input clock
`timescale 1ns/1ps
`default_nettype none
module mcsc_usb_div
  import mcsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // divider setting and output
  input wire logic [USB_DIV_W-1:0] div,
  output logic clk_en
);
  typedef struct packed {
    logic [USB_DIV_W-1:0] cnt;
    logic en;
  } mcsc_usb_state_t;

  mcsc_usb_state_t s;
  mcsc_usb_state_t next_s;

  always_comb begin
    next_s = s;
    // compare with >= so a smaller divider written mid-count takes effect at once
    if (s.cnt >= div) begin
      next_s.cnt = '0;
      next_s.en = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 4'h1;
      next_s.en = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clk_en = s.en;
endmodule : mcsc_usb_div
`default_nettype wire

// ==== src/mcsc_top.sv ====
// main clock source control: rc and crystal enables, start-up timing,
// glitch-free source selection, frequency meter, usb divider and registers
// assumes the analog oscillators and the clock mux cell sit outside and obey
// the enables and select driven here; oscillator ticks are core-synchronous
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - after reset the rc oscillator runs at 4 MHz and drives the main clock
// - rc_osc_enable turns the rc oscillator on and off
// - rc_freq_select picks one of three rc frequencies
// - clearing xtal_osc_enable clears xtal_ready_flag at once
// - enabling the crystal without bypass sets oscillator pin mode and starts the slow/8 countdown
// - the start-up count is an 8-bit field, about 62 ms at most
// - countdown reaching zero sets xtal_ready_flag
// - xtal_ready_flag raises the interrupt when its mask bit is set
// - a bypassable crystal oscillator is the second main clock source
// - main_src_select chooses the main clock source without glitches
// - main_src_switch_done in status reports a finished switch
// - main_src_switch_done raises the interrupt when its mask bit is set
// - rc is the default source and is selected again on wait mode entry
// - the frequency meter counts the selected main clock only
// - usb configuration writes are ignored while write_protect_enable is set
// - the usb clock is the input clock divided by usb_divider plus one
module mcsc_top
  import mcsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // system events and oscillator ticks
  input wire logic wait_mode_enter,
  input wire logic rc_clk_tick,
  input wire logic xtal_clk_tick,
  // oscillator controls
  output logic rc_osc_en,
  output logic [RC_FREQ_W-1:0] rc_freq_sel,
  output logic xtal_osc_en,
  output logic xtal_bypass,
  output logic xtal_pins_osc_mode,
  output logic main_clk_sel,
  // interrupt and usb clock
  output logic irq,
  output logic usb_clk_en
);
  typedef struct packed {
    logic rc_en;
    logic [RC_FREQ_W-1:0] rc_freq;
    logic xt_en;
    logic xt_bypass;
    logic [XT_COUNT_W-1:0] xt_count;
    logic src_req;
    logic src_eff;
    mcsc_xt_state_t xt_state;
    logic pins_osc;
    logic [RC_SETTLE_W-1:0] rc_settle;
    logic rc_ready;
    logic mask_xt;
    logic mask_sw;
    logic mask_rc;
    logic write_protect_enable;
    logic [USB_DIV_W-1:0] usb_div;
    logic [SLOW_DIV_W-1:0] slow_div;
    logic slow_tick;
    logic [MEAS_WIN_W-1:0] meas_win;
    logic [MEAS_W-1:0] meas_cnt;
    logic [MEAS_W-1:0] meas_val;
    logic meas_rdy;
    logic tmr_start;
    logic tmr_stop;
    logic [XT_COUNT_W-1:0] tmr_load;
    logic [31:0] rdata;
    logic irq;
  } mcsc_state_t;

  mcsc_state_t s;
  mcsc_state_t next_s;
  mcsc_tmr_if tmr ();

  logic wr_ctrl;
  logic xt_ready;
  logic sw_done;
  logic rc_restart;
  logic sel_tick;
  logic [RC_FREQ_W-1:0] wr_freq;
  logic [31:0] status_word;

  assign xt_ready = (s.xt_state == MCSC_XT_READY);
  assign sw_done = (s.src_eff == s.src_req);
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_OSC_CTRL);
  assign wr_freq = reg_wdata[RC_FREQ_LSB +: RC_FREQ_W];
  // the meter sees only the tick of whichever source the mux passes
  assign sel_tick = s.src_eff ? xtal_clk_tick : rc_clk_tick;

  always_comb begin
    status_word = 32'h0;
    status_word[B_XT_READY] = xt_ready;
    status_word[B_SW_DONE] = sw_done;
    status_word[B_RC_READY] = s.rc_ready;
  end

  always_comb begin
    next_s = s;
    next_s.tmr_start = 1'b0;
    next_s.tmr_stop = 1'b0;
    rc_restart = 1'b0;

    // slow clock enable from the core clock
    if (s.slow_div == SLOW_DIV_LAST) begin
      next_s.slow_div = '0;
      next_s.slow_tick = 1'b1;
    end else begin
      next_s.slow_div = s.slow_div + 11'h001;
      next_s.slow_tick = 1'b0;
    end

    // start-up done; a disabling write below still wins
    if (tmr.done && (s.xt_state == MCSC_XT_START)) begin
      next_s.xt_state = MCSC_XT_READY;
    end

    // oscillator control register
    if (wr_ctrl) begin
      next_s.rc_en = reg_wdata[B_RC_EN];
      if (reg_wdata[B_RC_EN] && !s.rc_en) begin
        rc_restart = 1'b1;
      end
      // unknown codes are dropped; a change while rc is off is only stored
      if ((wr_freq <= RC_FREQ_12MHZ) && (wr_freq != s.rc_freq)) begin
        next_s.rc_freq = wr_freq;
        if (s.rc_en) begin
          rc_restart = 1'b1;
        end
      end
      next_s.xt_en = reg_wdata[B_XT_EN];
      next_s.xt_bypass = reg_wdata[B_XT_BYPASS];
      next_s.xt_count = reg_wdata[XT_COUNT_LSB +: XT_COUNT_W];
      next_s.src_req = reg_wdata[B_SRC_SEL];
      if (reg_wdata[B_XT_EN] && !s.xt_en) begin
        // bypass takes an external clock, so no start-up wait is run
        next_s.xt_state = MCSC_XT_START;
        next_s.pins_osc = !reg_wdata[B_XT_BYPASS];
        next_s.tmr_start = 1'b1;
        next_s.tmr_load = reg_wdata[B_XT_BYPASS] ? '0 :
          reg_wdata[XT_COUNT_LSB +: XT_COUNT_W];
      end else if (!reg_wdata[B_XT_EN]) begin
        next_s.xt_state = MCSC_XT_OFF;
        next_s.pins_osc = 1'b0;
        next_s.tmr_stop = 1'b1;
      end
    end

    // wait mode returns to the rc source
    if (wait_mode_enter) begin
      next_s.src_req = 1'b0;
      next_s.rc_en = 1'b1;
      if (!s.rc_en) begin
        rc_restart = 1'b1;
      end
    end

    // rc settling
    if (rc_restart) begin
      next_s.rc_settle = RC_SETTLE_LOAD;
      next_s.rc_ready = 1'b0;
    end else if (!next_s.rc_en) begin
      next_s.rc_settle = '0;
      next_s.rc_ready = 1'b0;
    end else if (s.rc_settle != '0) begin
      next_s.rc_settle = s.rc_settle - 10'h001;
    end else begin
      next_s.rc_ready = 1'b1;
    end

    // source switch: move only onto a valid source
    if (!sw_done) begin
      if (s.src_req ? xt_ready : s.rc_ready) begin
        next_s.src_eff = s.src_req;
      end
    end
    // a crystal lost while in use falls back to the rc oscillator once rc is ready
    if (s.src_eff && !xt_ready && s.rc_ready) begin
      next_s.src_eff = 1'b0;
    end

    // frequency meter over sixteen slow clock periods
    if (sel_tick && (s.meas_cnt != MEAS_MAX)) begin
      next_s.meas_cnt = s.meas_cnt + 16'h0001;
    end
    if (s.slow_tick) begin
      if (s.meas_win == MEAS_WIN_LAST) begin
        next_s.meas_win = '0;
        next_s.meas_val = s.meas_cnt;
        next_s.meas_rdy = 1'b1;
        next_s.meas_cnt = '0;
      end else begin
        next_s.meas_win = s.meas_win + 4'h1;
      end
    end

    // remaining writable registers
    if (reg_wr && (reg_addr == ADDR_IRQ_MASK)) begin
      next_s.mask_xt = reg_wdata[B_XT_READY];
      next_s.mask_sw = reg_wdata[B_SW_DONE];
      next_s.mask_rc = reg_wdata[B_RC_READY];
    end
    if (reg_wr && (reg_addr == ADDR_WPROT)) begin
      next_s.write_protect_enable = reg_wdata[B_WRITE_PROTECT_ENABLE];
    end
    if (reg_wr && (reg_addr == ADDR_USB_CFG) && !s.write_protect_enable) begin
      next_s.usb_div = reg_wdata[USB_DIV_LSB +: USB_DIV_W];
    end

    // read data stands one cycle after the strobe, zero otherwise
    next_s.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_OSC_CTRL: begin
          next_s.rdata[B_XT_EN] = s.xt_en;
          next_s.rdata[B_XT_BYPASS] = s.xt_bypass;
          next_s.rdata[B_RC_EN] = s.rc_en;
          next_s.rdata[RC_FREQ_LSB +: RC_FREQ_W] = s.rc_freq;
          next_s.rdata[XT_COUNT_LSB +: XT_COUNT_W] = s.xt_count;
          next_s.rdata[B_SRC_SEL] = s.src_req;
        end
        ADDR_FREQ_METER: begin
          next_s.rdata[MEAS_W-1:0] = s.meas_val;
          next_s.rdata[B_MEAS_READY] = s.meas_rdy;
        end
        ADDR_USB_CFG: begin
          next_s.rdata[USB_DIV_LSB +: USB_DIV_W] = s.usb_div;
        end
        ADDR_STATUS: begin
          next_s.rdata = status_word;
        end
        ADDR_IRQ_MASK: begin
          next_s.rdata[B_XT_READY] = s.mask_xt;
          next_s.rdata[B_SW_DONE] = s.mask_sw;
          next_s.rdata[B_RC_READY] = s.mask_rc;
        end
        ADDR_WPROT: begin
          next_s.rdata[B_WRITE_PROTECT_ENABLE] = s.write_protect_enable;
        end
        default: begin
          next_s.rdata = 32'h0;
        end
      endcase
    end

    // level interrupt from masked status levels
    next_s.irq = (xt_ready && s.mask_xt) ||
      (sw_done && s.mask_sw) ||
      (s.rc_ready && s.mask_rc);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.rc_en <= 1'b1;
      s.rc_freq <= RC_FREQ_4MHZ;
      s.rc_ready <= 1'b1;
      s.src_req <= 1'b0;
      s.src_eff <= 1'b0;
      s.xt_state <= MCSC_XT_OFF;
    end else begin
      s <= next_s;
    end
  end

  assign tmr.slow_tick = s.slow_tick;
  assign tmr.start = s.tmr_start;
  assign tmr.stop = s.tmr_stop;
  assign tmr.load = s.tmr_load;

  mcsc_xt_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .tb(tmr.timer)
  );

  mcsc_usb_div u_usb_div (
    .core_clk(core_clk),
    .rst(rst),
    .div(s.usb_div),
    .clk_en(usb_clk_en)
  );

  assign reg_rdata = s.rdata;
  assign rc_osc_en = s.rc_en;
  assign rc_freq_sel = s.rc_freq;
  assign xtal_osc_en = s.xt_en;
  assign xtal_bypass = s.xt_bypass;
  assign xtal_pins_osc_mode = s.pins_osc;
  assign main_clk_sel = s.src_eff;
  assign irq = s.irq;
endmodule : mcsc_top
`default_nettype wire

// ==== verification/mcsc_monitor.sv ====
// checker on the main clock source control top ports
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module mcsc_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // events and oscillator controls
  input wire logic wait_mode_enter,
  input wire logic rc_osc_en,
  input wire logic [mcsc_pkg::RC_FREQ_W-1:0] rc_freq_sel,
  input wire logic xtal_osc_en,
  input wire logic xtal_bypass,
  input wire logic xtal_pins_osc_mode,
  input wire logic main_clk_sel
);
  import mcsc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic wr_ctrl = reg_wr && (reg_addr == ADDR_OSC_CTRL);
  // crystal start from off, not bypassed
  sequence s_xt_on;
    wr_ctrl && reg_wdata[B_XT_EN] && !reg_wdata[B_XT_BYPASS] && !xtal_osc_en;
  endsequence
  // pins flip at once, mux must not follow for the next two cycles
  sequence s_xt_wait;
    xtal_osc_en && xtal_pins_osc_mode ##1 !main_clk_sel [*2];
  endsequence
  property p_reset;
    $fell(rst) |-> rc_osc_en && rc_freq_sel == 3'h0 && !main_clk_sel && !xtal_osc_en;
  endproperty
  property p_rc_en;
    wr_ctrl && !wait_mode_enter |=> rc_osc_en == $past(reg_wdata[B_RC_EN]);
  endproperty
  property p_rc_freq;
    wr_ctrl && reg_wdata[6:4] <= 3'h2 |=> rc_freq_sel == $past(reg_wdata[6:4]);
  endproperty
  property p_rc_keep;
    wr_ctrl && reg_wdata[6:4] > 3'h2 |=> $stable(rc_freq_sel);
  endproperty
  property p_xt_off;
    wr_ctrl && !reg_wdata[B_XT_EN] |=> !xtal_osc_en && !xtal_pins_osc_mode;
  endproperty
  property p_xt_start;
    s_xt_on |=> s_xt_wait;
  endproperty
  property p_bypass;
    wr_ctrl |=> xtal_bypass == $past(reg_wdata[B_XT_BYPASS]);
  endproperty
  property p_sel_valid;
    $rose(main_clk_sel) |-> xtal_osc_en;
  endproperty
  property p_wait;
    wait_mode_enter |-> ##[1:600] (rc_osc_en && !main_clk_sel);
  endproperty
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_rc_en: assert property (p_rc_en) else $error("rc enable wrong");
  a_rc_freq: assert property (p_rc_freq) else $error("rc freq wrong");
  a_rc_keep: assert property (p_rc_keep) else $error("bad freq code taken");
  a_xt_off: assert property (p_xt_off) else $error("crystal not off");
  a_xt_start: assert property (p_xt_start) else $error("crystal start wrong");
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  a_sel_valid: assert property (p_sel_valid) else $error("mux to dead source");
  a_wait: assert property (p_wait) else $error("wait mode not on rc");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule : mcsc_monitor
bind mcsc_top mcsc_monitor mcsc_monitor_inst (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wait_mode_enter(wait_mode_enter), .rc_osc_en(rc_osc_en),
  .rc_freq_sel(rc_freq_sel), .xtal_osc_en(xtal_osc_en), .xtal_bypass(xtal_bypass),
  .xtal_pins_osc_mode(xtal_pins_osc_mode), .main_clk_sel(main_clk_sel));
`default_nettype wire

// ==== verification/mcsc_osc_model.sv ====
// oscillator partner: rc and crystal tick sources
// assumes ticks are core-synchronous one-cycle enables
`timescale 1ns/1ps
`default_nettype none
module mcsc_osc_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // controls from the block
  input wire logic rc_osc_en,
  input wire logic xtal_osc_en,
  input wire logic xtal_bypass,
  input wire logic xtal_pins_osc_mode,
  // ticks to the block
  output logic rc_clk_tick,
  output logic xtal_clk_tick
);
  logic ph;
  always_ff @(posedge core_clk) begin
    ph <= rst ? 1'b0 : !ph;
  end
  // rc ticks every cycle, only while enabled
  assign rc_clk_tick = rc_osc_en;
  // crystal at half rate; stands still unless driven or bypassed
  assign xtal_clk_tick = xtal_osc_en && (xtal_pins_osc_mode || xtal_bypass) && ph;
endmodule : mcsc_osc_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the main clock source control block
// assumes the oscillator partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mcsc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wait_mode_enter = 1'b0;
  logic [31:0] reg_rdata;
  logic rc_clk_tick, xtal_clk_tick, rc_osc_en, xtal_osc_en, xtal_bypass;
  logic xtal_pins_osc_mode, main_clk_sel, irq, usb_clk_en;
  logic [2:0] rc_freq_sel;
  logic [31:0] d;
  int fails = 0;
  int n_checks = 0;
  int ctrl_m = 8;
  int usb_m = 0;
  int wp_m = 0;
  int k;
  always #10 core_clk = !core_clk;
  mcsc_top mcsc_top_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .wait_mode_enter, .rc_clk_tick, .xtal_clk_tick, .rc_osc_en, .rc_freq_sel,
    .xtal_osc_en, .xtal_bypass, .xtal_pins_osc_mode, .main_clk_sel, .irq, .usb_clk_en);
  mcsc_osc_model mcsc_osc_model_inst (.core_clk, .rst, .rc_osc_en, .xtal_osc_en,
    .xtal_bypass, .xtal_pins_osc_mode, .rc_clk_tick, .xtal_clk_tick);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
    // bad freq codes leave the old code in place
    if (a == ADDR_OSC_CTRL) ctrl_m = (v[6:4] > 3'h2) ? ((v & ~32'h70) | (ctrl_m & 32'h70)) : v;
    if (a == ADDR_USB_CFG && wp_m == 0) usb_m = v;
    if (a == ADDR_WPROT) wp_m = v;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    check(d, exp);
  endtask : rd_chk
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask : wait_for
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h581edd96));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check(rc_osc_en, 1'b1);
    check(rc_freq_sel, RC_FREQ_4MHZ);
    rd_chk(ADDR_OSC_CTRL, ctrl_m);
    rd_chk(ADDR_STATUS, 32'h30000);
    wr(32'h400e0500, 32'hffffffff);
    rd_chk(32'h400e0500, 32'h0);
    wr(ADDR_OSC_CTRL, 32'h0);
    check(rc_osc_en, 1'b0);
    wr(ADDR_OSC_CTRL, 32'h8);
    check(rc_osc_en, 1'b1);
    rd_chk(ADDR_STATUS, 32'h10000);
    // rc already on, so each freq change is a later write
    for (k = 0; k < 8; k++) begin
      wr(ADDR_OSC_CTRL, 32'h8 | (((k < 4) ? k : $urandom % 8) << 4));
      check(rc_freq_sel, ctrl_m[6:4]);
      rd_chk(ADDR_OSC_CTRL, ctrl_m);
    end
    // back to 4 MHz so later control writes leave the rc settled
    wr(ADDR_OSC_CTRL, 32'h8);
    check(rc_freq_sel, RC_FREQ_4MHZ);
    repeat (510) @(posedge core_clk);
    rd_chk(ADDR_STATUS, 32'h30000);
    wr(ADDR_IRQ_MASK, 32'h1);
    // a count of one keeps the wait near eight slow periods
    wr(ADDR_OSC_CTRL, 32'h109);
    check(xtal_pins_osc_mode, 1'b1);
    rd_chk(ADDR_STATUS, 32'h30000);
    repeat (10000) @(posedge core_clk);
    check(irq, 1'b0);
    wait_for(irq, 1'b1, 3000);
    check(irq, 1'b1);
    rd_chk(ADDR_STATUS, 32'h30001);
    wr(ADDR_OSC_CTRL, 32'h01000109);
    wait_for(main_clk_sel, 1'b1, 4);
    check(main_clk_sel, 1'b1);
    rd_chk(ADDR_STATUS, 32'h30001);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge core_clk);
    check(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h10000);
    repeat (3) @(posedge core_clk);
    check(irq, 1'b1);
    // two windows so the last one sees only the crystal
    repeat (49000) @(posedge core_clk);
    rd(ADDR_FREQ_METER);
    check(d[16], 1'b1);
    check(d[15:0] >= 16'd12150 && d[15:0] <= 16'd12250, 1'b1);
    @(posedge core_clk);
    wait_mode_enter <= 1'b1;
    @(posedge core_clk);
    wait_mode_enter <= 1'b0;
    wait_for(main_clk_sel, 1'b0, 10);
    check(main_clk_sel, 1'b0);
    ctrl_m[24] = 1'b0;
    rd_chk(ADDR_OSC_CTRL, ctrl_m);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_OSC_CTRL, 32'h8);
    check(xtal_osc_en, 1'b0);
    rd_chk(ADDR_STATUS, 32'h30000);
    check(irq, 1'b0);
    wr(ADDR_OSC_CTRL, 32'hb);
    check({xtal_bypass, xtal_pins_osc_mode}, 2'b10);
    wait_for(irq, 1'b1, 10);
    rd_chk(ADDR_STATUS, 32'h30001);
    wr(ADDR_USB_CFG, 32'h300);
    wait_for(usb_clk_en, 1'b1, 20);
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (usb_clk_en !== 1'b1 && k < 20);
    check(k, 4);
    wr(ADDR_WPROT, 32'h1);
    wr(ADDR_USB_CFG, 32'h500);
    rd_chk(ADDR_USB_CFG, usb_m);
    wr(ADDR_WPROT, 32'h0);
    wr(ADDR_USB_CFG, 32'h500);
    rd_chk(ADDR_USB_CFG, usb_m);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
